// [inc/touch_power_status_map.vh]
`ifndef TOUCH_POWER_STATUS_MAP_VH
`define TOUCH_POWER_STATUS_MAP_VH

// ************************************************************
// Register offsets
// ************************************************************
`define MAIN_POWER_CONTROL_ADDR 8'h00
`define GENERAL_EVENT_STATUS_ADDR 8'h02
`define CHANNEL_TOUCH_STATUS_ADDR 8'h03
`define LED_DONE_STATUS_ADDR 8'h04
`define CHANNEL_NOISE_STATUS_ADDR 8'h0A

// ************************************************************
// Main control fields
// ************************************************************
`define MAIN_GAIN_HI 7
`define MAIN_GAIN_LO 6
`define MAIN_STANDBY_BIT 5
`define MAIN_DEEP_SLEEP_BIT 4
`define MAIN_INT_BIT 0

// ************************************************************
// General status fields
// ************************************************************
`define GEN_LED_DONE_BIT 4
`define GEN_RESET_SEEN_BIT 3
`define GEN_MULTI_BLOCK_BIT 2
`define GEN_PATTERN_BIT 1
`define GEN_TOUCH_BIT 0

// ************************************************************
// Reset values
// ************************************************************
`define MAIN_POWER_CONTROL_RST 8'h00
`define STATUS_RST 8'h00
`define LED_DONE_RST 2'h0
`define READ_UNMAPPED 8'h00

`endif

// [verilog/pin_sync3.v]
`timescale 1ns/1ns
// Three-stage pin synchroniser; the output only moves once the second
// and third stages agree, which also rejects a one-cycle glitch.
module pin_sync3 (
    input wire clk_sys_in,
    input wire rstn_in,
    input wire pin_in,
    output wire level_out
);
    reg stage1_reg;
    reg stage2_reg;
    reg stage3_reg;
    reg level_reg;

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (stage2_reg == stage3_reg) begin
                level_reg <= stage3_reg;
            end
        end
    end

    assign level_out = level_reg;
endmodule // pin_sync3

// [verilog/touch_power_status_regs.v]
`timescale 1ns/1ns
`include "touch_power_status_map.vh"

module touch_power_status_regs (
    input wire clk_sys_in,
    input wire rstn_in,
    // Parallel side of the serial register bus
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output wire [7:0] reg_rdata_out,
    // Sensing front end, same clock
    input wire [7:0] touch_detect_in,
    input wire [7:0] chan_int_enable_in,
    input wire [7:0] standby_chan_in,
    input wire [7:0] noise_lowfreq_in,
    input wire [7:0] noise_rf_in,
    input wire [63:0] delta_raw_in,
    input wire [7:0] pattern_above_in,
    input wire [3:0] pattern_limit_in,
    input wire pattern_detect_enable_in,
    input wire pattern_alert_enable_in,
    input wire multi_touch_block_in,
    input wire lowfreq_noise_filter_off_in,
    input wire rf_noise_filter_off_in,
    input wire wake_cfg_in,
    input wire spi4_mode_in,
    input wire reset_pin_qualified_in,
    // LED_DONE_SUMMARY engines
    input wire [1:0] led_finish_in,
    input wire [1:0] led_linked_in,
    // Shared wake / serial data pin
    input wire wake_pin_in,
    output wire wake_pin_out,
    output wire wake_pin_oe_out,
    // Controls towards the core
    output wire alert_n_out,
    output wire [3:0] gain_multi_touch_block_flag_out,
    output wire [7:0] scan_mask_out,
    output wire led_idle_force_out,
    output wire pwm_enable_out,
    output wire [7:0] sample_discard_out,
    output wire [63:0] delta_out
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function [3:0] popcount8;
        input [7:0] vec;
        integer i;
        begin
            popcount8 = 4'h0;
            for (i = 0; i < 8; i = i + 1) begin
                popcount8 = popcount8 + {3'h0, vec[i]};
            end
        end
    endfunction

    function [3:0] gain_decode;
        input [1:0] code;
        begin
            case (code)
                2'h0: gain_decode = 4'h1;
                2'h1: gain_decode = 4'h2;
                2'h2: gain_decode = 4'h4;
                default: gain_decode = 4'h8;
            endcase
        end
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    reg [1:0] gain_reg;
    reg standby_enable_reg;
    reg deep_sleep_enable_reg;
    reg int_flag_reg;
    reg [7:0] chan_touched_reg;
    reg [7:0] touch_seen_reg;
    reg [1:0] led_finished_reg;
    reg reset_seen_reg;
    reg pattern_match_flag_reg;
    reg pattern_cond_reg;
    reg multi_touch_block_flag_reg;
    reg [7:0] chan_noisy_reg;
    reg wake_assert_reg;
    reg por_pending_reg;
    reg [7:0] rdata_reg;
    reg [63:0] delta_reg;

    reg [1:0] gain_next;
    reg standby_enable_next;
    reg deep_sleep_enable_next;
    reg int_flag_next;
    reg [7:0] chan_touched_next;
    reg [1:0] led_finished_next;
    reg reset_seen_next;
    reg pattern_match_flag_next;
    reg wake_assert_next;
    reg [7:0] rdata_next;
    reg [63:0] delta_next;

    wire wake_level;
    wire main_wr;
    wire int_clear;
    wire [7:0] noisy_now;
    wire [7:0] touch_live;
    wire [7:0] touch_rise;
    wire [7:0] pattern_chans;
    wire pattern_cond;
    wire pattern_rise;
    wire int_set;
    wire led_done_summary;
    wire touch_summary;
    wire wake_request;
    wire [7:0] main_value;
    wire [7:0] general_value;
    integer ch;

    pin_sync3 wake_sync (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .pin_in(wake_pin_in),
        .level_out(wake_level)
    );

    // ************************************************************
    // Scan, noise and pattern conditions
    // ************************************************************
    assign scan_mask_out = deep_sleep_enable_reg ? 8'h00 :
        (standby_enable_reg ? standby_chan_in : 8'hFF);
    assign gain_multi_touch_block_flag_out = gain_decode(gain_reg);
    assign led_idle_force_out = deep_sleep_enable_reg;
    assign pwm_enable_out = ~deep_sleep_enable_reg;

    assign noisy_now = noise_lowfreq_in | noise_rf_in;
    assign sample_discard_out =
        (noise_lowfreq_in & {8{~lowfreq_noise_filter_off_in}}) |
        (noise_rf_in & {8{~rf_noise_filter_off_in}});

    // Unscanned channels simply fall to untouched, giving one release
    assign touch_live = touch_detect_in & scan_mask_out
        & ~chan_noisy_reg;
    assign touch_rise = touch_live & ~touch_seen_reg;

    // OR before counting so a channel over threshold and noisy counts once
    assign pattern_chans = pattern_above_in | chan_noisy_reg;
    assign pattern_cond = pattern_detect_enable_in
        & ~deep_sleep_enable_reg
        & (popcount8(pattern_chans) > pattern_limit_in);
    assign pattern_rise = pattern_cond & ~pattern_cond_reg;

    // Multi-touch suppression is reported but never interrupts
    assign int_set = (|(touch_rise & chan_int_enable_in))
        | por_pending_reg | reset_pin_qualified_in
        | (pattern_rise & pattern_alert_enable_in)
        | (|(led_finish_in & ~led_linked_in));

    // ************************************************************
    // Register writes
    // ************************************************************
    assign main_wr = reg_wr_in
        & (reg_addr_in == `MAIN_POWER_CONTROL_ADDR);
    // Any zero written to the flag is a clear, even with the flag already low
    assign int_clear = main_wr & ~reg_wdata_in[`MAIN_INT_BIT];
    // Our own drive reads back on the pin, so only a foreign level wakes
    assign wake_request = wake_level & ~wake_pin_oe_out;

    always @* begin
        gain_next = gain_reg;
        standby_enable_next = standby_enable_reg;
        deep_sleep_enable_next = deep_sleep_enable_reg;
        if (main_wr) begin
            gain_next = reg_wdata_in[`MAIN_GAIN_HI:`MAIN_GAIN_LO];
            standby_enable_next = reg_wdata_in[`MAIN_STANDBY_BIT];
            deep_sleep_enable_next = reg_wdata_in[`MAIN_DEEP_SLEEP_BIT];
        end
        if (wake_request) begin
            deep_sleep_enable_next = 1'b0;
        end
    end

    // ************************************************************
    // Status and interrupt flag; a set beats a host clear, deep sleep beats both
    // ************************************************************
    always @* begin
        int_flag_next = int_flag_reg;
        if (main_wr) begin
            int_flag_next = reg_wdata_in[`MAIN_INT_BIT];
        end
        if (int_set) begin
            int_flag_next = 1'b1;
        end

        chan_touched_next = chan_touched_reg | touch_rise;
        if (int_clear) begin
            chan_touched_next = (chan_touched_reg & touch_live)
                | touch_rise;
        end

        led_finished_next = led_finished_reg
            | (led_finish_in & ~led_linked_in);
        if (int_clear) begin
            led_finished_next = led_finish_in & ~led_linked_in;
        end

        reset_seen_next = reset_seen_reg;
        if (int_clear) begin
            reset_seen_next = 1'b0;
        end
        if (por_pending_reg | reset_pin_qualified_in) begin
            reset_seen_next = 1'b1;
        end

        pattern_match_flag_next = pattern_match_flag_reg | pattern_cond;
        if (int_clear) begin
            pattern_match_flag_next = pattern_cond;
        end

        // Wake only for standby touches that actually raised the flag
        wake_assert_next = wake_assert_reg;
        if (int_clear) begin
            wake_assert_next = 1'b0;
        end
        if (standby_enable_reg & wake_cfg_in
            & (|(touch_rise & chan_int_enable_in))) begin
            wake_assert_next = 1'b1;
        end

        // Deep sleep wipes all but the multi-touch and noise flags from its entry edge, so no event
        // landing on that edge can leave the alert asserted while asleep
        if (deep_sleep_enable_next) begin
            int_flag_next = 1'b0;
            chan_touched_next = `STATUS_RST;
            led_finished_next = `LED_DONE_RST;
            reset_seen_next = 1'b0;
            pattern_match_flag_next = 1'b0;
            wake_assert_next = 1'b0;
        end
    end

    // ************************************************************
    // Delta gating
    // ************************************************************
    always @* begin
        delta_next = delta_raw_in;
        for (ch = 0; ch < 8; ch = ch + 1) begin
            if (noisy_now[ch]) begin
                delta_next[ch*8 +: 8] = 8'h00;
            end
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    assign led_done_summary = |led_finished_reg;
    assign touch_summary = |chan_touched_reg;
    assign main_value = {gain_reg, standby_enable_reg,
        deep_sleep_enable_reg, 3'h0, int_flag_reg};
    assign general_value = {3'h0, led_done_summary, reset_seen_reg,
        multi_touch_block_flag_reg, pattern_match_flag_reg,
        touch_summary};

    always @* begin
        rdata_next = rdata_reg;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `MAIN_POWER_CONTROL_ADDR: rdata_next = main_value;
                `GENERAL_EVENT_STATUS_ADDR: rdata_next = general_value;
                `CHANNEL_TOUCH_STATUS_ADDR: rdata_next = chan_touched_reg;
                `LED_DONE_STATUS_ADDR:
                    rdata_next = {6'h00, led_finished_reg};
                `CHANNEL_NOISE_STATUS_ADDR: rdata_next = chan_noisy_reg;
                default: rdata_next = `READ_UNMAPPED;
            endcase
        end
    end

    // ************************************************************
    // Flops
    // ************************************************************
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gain_reg <= 2'h0;
            standby_enable_reg <= 1'b0;
            deep_sleep_enable_reg <= 1'b0;
            int_flag_reg <= 1'b0;
            chan_touched_reg <= `STATUS_RST;
            touch_seen_reg <= 8'h00;
            led_finished_reg <= `LED_DONE_RST;
            reset_seen_reg <= 1'b0;
            pattern_match_flag_reg <= 1'b0;
            pattern_cond_reg <= 1'b0;
            multi_touch_block_flag_reg <= 1'b0;
            chan_noisy_reg <= 8'h00;
            wake_assert_reg <= 1'b0;
            por_pending_reg <= 1'b1;
            rdata_reg <= `READ_UNMAPPED;
            delta_reg <= 64'h0;
        end else begin
            gain_reg <= gain_next;
            standby_enable_reg <= standby_enable_next;
            deep_sleep_enable_reg <= deep_sleep_enable_next;
            int_flag_reg <= int_flag_next;
            chan_touched_reg <= chan_touched_next;
            touch_seen_reg <= touch_live;
            led_finished_reg <= led_finished_next;
            reset_seen_reg <= reset_seen_next;
            pattern_match_flag_reg <= pattern_match_flag_next;
            pattern_cond_reg <= pattern_cond;
            multi_touch_block_flag_reg <= multi_touch_block_in
                & ~deep_sleep_enable_reg;
            chan_noisy_reg <= noisy_now
                & {8{~deep_sleep_enable_reg}};
            wake_assert_reg <= wake_assert_next;
            por_pending_reg <= 1'b0;
            rdata_reg <= rdata_next;
            delta_reg <= delta_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign alert_n_out = ~int_flag_reg;
    assign wake_pin_out = 1'b1;
    // In four-wire SPI the pin is data in, so it is never driven
    assign wake_pin_oe_out = wake_assert_reg & ~spi4_mode_in;
    assign reg_rdata_out = rdata_reg;
    assign delta_out = delta_reg;

endmodule // touch_power_status_regs

// [dv/reg_host_model.sv]
`timescale 1ns/1ns
// Host side of the register port; pin names mirror the block's port
module reg_host_model (
    input wire clk_sys_in,
    input wire [7:0] reg_rdata_out,
    output reg [7:0] reg_addr_in,
    output reg [7:0] reg_wdata_in,
    output reg reg_wr_in,
    output reg reg_rd_in
);
    initial begin
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
    end

    // A zero in the flag bit is how the host acknowledges an event
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask

    // Data is registered one cycle after the strobe edge
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
endmodule // reg_host_model

// [dv/touch_power_status_monitor.sv]
`timescale 1ns/1ns
module touch_power_status_monitor (
    input wire clk_sys_in,
    input wire rstn_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire [7:0] standby_chan_in,
    input wire [7:0] noise_lowfreq_in,
    input wire [7:0] noise_rf_in,
    input wire lowfreq_noise_filter_off_in,
    input wire rf_noise_filter_off_in,
    input wire spi4_mode_in,
    input wire wake_pin_in,
    input wire wake_pin_oe_out,
    input wire alert_n_out,
    input wire [3:0] gain_multi_touch_block_flag_out,
    input wire [7:0] scan_mask_out,
    input wire led_idle_force_out,
    input wire pwm_enable_out,
    input wire [7:0] sample_discard_out,
    input wire [63:0] delta_out
);
    // ************************************************************
    // Port relations
    // ************************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    property p_unmapped_read;
        reg_rd_in && !(reg_addr_in inside {8'h00, 8'h02, 8'h03, 8'h04,
            8'h0A}) |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned nonzero");

    property p_gain_decode;
        reg_wr_in && reg_addr_in == 8'h00
            |=> gain_multi_touch_block_flag_out == (4'h1 << $past(reg_wdata_in[7:6]));
    endproperty
    a_gain_decode: assert property (p_gain_decode)
        else $error("gain multiplier does not match code");

    property p_scan_select;
        reg_wr_in && reg_addr_in == 8'h00 && !reg_wdata_in[4]
            |=> scan_mask_out == ($past(reg_wdata_in[5]) ?
            standby_chan_in : 8'hFF);
    endproperty
    a_scan_select: assert property (p_scan_select)
        else $error("scan mask wrong after control write");

    property p_flag_alert;
        reg_rd_in && reg_addr_in == 8'h00
            |=> reg_rdata_out[0] == !$past(alert_n_out);
    endproperty
    a_flag_alert: assert property (p_flag_alert)
        else $error("alert level disagrees with flag");

    property p_unused_zero;
        reg_rd_in && reg_addr_in == 8'h04 |=> reg_rdata_out[7:2] == 6'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused status bits not zero");

    property p_sleep_quiet;
        led_idle_force_out |-> !pwm_enable_out && alert_n_out;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("activity or alert during deep sleep");

    property p_wake_exit;
        (wake_pin_in && !wake_pin_oe_out && !reg_wr_in) [*8]
            |-> !led_idle_force_out;
    endproperty
    a_wake_exit: assert property (p_wake_exit)
        else $error("deep sleep held with wake pin high");

    property p_spi4_no_drive;
        spi4_mode_in |-> !wake_pin_oe_out;
    endproperty
    a_spi4_no_drive: assert property (p_spi4_no_drive)
        else $error("wake pin driven in four wire mode");

    property p_noise_zeroes_delta;
        (noise_lowfreq_in[0] || noise_rf_in[0]) [*2]
            |=> delta_out[7:0] == 8'h00;
    endproperty
    a_noise_zeroes_delta: assert property (p_noise_zeroes_delta)
        else $error("noisy channel delta not zero");

    property p_discard;
        sample_discard_out ==
            ((noise_lowfreq_in & {8{~lowfreq_noise_filter_off_in}}) |
            (noise_rf_in & {8{~rf_noise_filter_off_in}}));
    endproperty
    a_discard: assert property (p_discard)
        else $error("sample discard mask wrong");

    c_alert_fall: cover property ($fell(alert_n_out));
    c_sleep_exit: cover property ($fell(led_idle_force_out));
    c_wake_drive: cover property ($rose(wake_pin_oe_out));
endmodule // touch_power_status_monitor

bind touch_power_status_regs touch_power_status_monitor
    u_touch_power_status_monitor (.*);

// [dv/touch_power_status_regs_tb.sv]
`timescale 1ns/1ns
module touch_power_status_regs_tb;
    reg clk_sys_in;
    reg rstn_in;
    reg [7:0] touch_detect_in, chan_int_enable_in, standby_chan_in;
    reg [7:0] noise_lowfreq_in, noise_rf_in, pattern_above_in;
    reg [63:0] delta_raw_in;
    reg [3:0] pattern_limit_in;
    reg pattern_detect_enable_in, pattern_alert_enable_in;
    reg multi_touch_block_in, wake_cfg_in, spi4_mode_in, wake_pin_in;
    reg lowfreq_noise_filter_off_in, rf_noise_filter_off_in;
    reg reset_pin_qualified_in;
    reg [1:0] led_finish_in, led_linked_in;
    wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, scan_mask_out;
    wire [7:0] sample_discard_out;
    wire reg_wr_in, reg_rd_in, wake_pin_out, wake_pin_oe_out, alert_n_out;
    wire led_idle_force_out, pwm_enable_out;
    wire [3:0] gain_multi_touch_block_flag_out;
    wire [63:0] delta_out;
    integer miscompares = 0;
    integer tests_run = 0;
    integer cycles = 0;
    integer i;
    reg [7:0] rv;

    touch_power_status_regs u_touch_power_status_regs (.*);
    reg_host_model u_reg_host_model (.*);

    // ************************************************************
    // Helpers
    // ************************************************************
    task stop_test;
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string n, input [63:0] seen, input [63:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task rdc(input [7:0] a, input [7:0] e);
        u_reg_host_model.rd(a, rv);
        chk($sformatf("reg_%h", a), rv, e);
    endtask

    task wr(input [7:0] a, input [7:0] d);
        u_reg_host_model.wr(a, d);
    endtask

    task tick(input integer n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // Whole sequence needs well under a thousand cycles
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            stop_test;
        end
    end

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        {touch_detect_in, chan_int_enable_in, standby_chan_in} = 24'h0;
        {noise_lowfreq_in, noise_rf_in, pattern_above_in} = 24'h0;
        delta_raw_in = 64'h8877665544332211;
        pattern_limit_in = 4'h1;
        {pattern_detect_enable_in, pattern_alert_enable_in} = 2'h0;
        {multi_touch_block_in, wake_cfg_in, spi4_mode_in} = 3'h0;
        {wake_pin_in, lowfreq_noise_filter_off_in} = 2'h0;
        {rf_noise_filter_off_in, reset_pin_qualified_in} = 2'h0;
        {led_finish_in, led_linked_in} = 4'h0;
        rstn_in = 1'b0;
        tick(6);
        rstn_in <= 1'b1;
        rdc(8'h00, 8'h01);
        rdc(8'h02, 8'h08);
        rdc(8'h03, 8'h00);
        rdc(8'h04, 8'h00);
        rdc(8'h0A, 8'h00);
        wr(8'h01, 8'hFF);
        wr(8'hFF, 8'hFF);
        rdc(8'h01, 8'h00);
        rdc(8'hFF, 8'h00);
        rdc(8'h00, 8'h01);
        wr(8'h00, 8'h00);
        #1 chk("alert_n", alert_n_out, 1'b1);
        rdc(8'h02, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h00, {i[1:0], 6'h0E});
            #1 chk("gain", gain_multi_touch_block_flag_out, 4'h1 << i);
            rdc(8'h00, {i[1:0], 6'h00});
        end
        wr(8'h00, 8'h00);
        // Touch on a channel without interrupt enable
        tick(1);
        chan_int_enable_in <= 8'h01;
        touch_detect_in <= 8'h02;
        tick(3);
        #1 chk("alert_n", alert_n_out, 1'b1);
        tick(1);
        touch_detect_in <= 8'h00;
        wr(8'h00, 8'h00);
        tick(1);
        touch_detect_in <= 8'h01;
        tick(3);
        #1 chk("alert_n", alert_n_out, 1'b0);
        rdc(8'h03, 8'h01);
        rdc(8'h02, 8'h01);
        wr(8'h00, 8'h00);
        rdc(8'h03, 8'h01);
        tick(3);
        #1 chk("alert_n", alert_n_out, 1'b1);
        tick(1);
        touch_detect_in <= 8'h00;
        wr(8'h00, 8'h00);
        rdc(8'h03, 8'h00);
        rdc(8'h02, 8'h00);
        // Standby with wake output
        tick(1);
        standby_chan_in <= 8'h04;
        chan_int_enable_in <= 8'h04;
        touch_detect_in <= 8'h01;
        wake_cfg_in <= 1'b1;
        wr(8'h00, 8'h20);
        #1 chk("scan_mask", scan_mask_out, 8'h04);
        tick(1);
        touch_detect_in <= 8'h05;
        tick(3);
        #1 chk("wake_oe", wake_pin_oe_out, 1'b1);
        chk("wake_out", wake_pin_out, 1'b1);
        tick(1);
        spi4_mode_in <= 1'b1;
        tick(1);
        #1 chk("wake_oe", wake_pin_oe_out, 1'b0);
        tick(1);
        spi4_mode_in <= 1'b0;
        // Input 1 stays pressed but is not scanned in standby
        touch_detect_in <= 8'h01;
        wr(8'h00, 8'h20);
        #1 chk("wake_oe", wake_pin_oe_out, 1'b0);
        rdc(8'h03, 8'h00);
        tick(1);
        wake_cfg_in <= 1'b0;
        touch_detect_in <= 8'h04;
        tick(3);
        #1 chk("wake_oe", wake_pin_oe_out, 1'b0);
        tick(1);
        touch_detect_in <= 8'h00;
        wr(8'h00, 8'h00);
        #1 chk("scan_mask", scan_mask_out, 8'hFF);
        // LED_DONE_SUMMARY completion, host driven then linked
        tick(1);
        led_finish_in <= 2'b10;
        tick(1);
        led_finish_in <= 2'b00;
        rdc(8'h04, 8'h02);
        rdc(8'h02, 8'h10);
        wr(8'h00, 8'h00);
        rdc(8'h04, 8'h00);
        tick(1);
        led_linked_in <= 2'b01;
        led_finish_in <= 2'b01;
        tick(1);
        led_finish_in <= 2'b00;
        rdc(8'h04, 8'h00);
        // Multi-touch blocking, pattern and noise
        tick(1);
        multi_touch_block_in <= 1'b1;
        tick(3);
        #1 chk("alert_n", alert_n_out, 1'b1);
        rdc(8'h02, 8'h04);
        tick(1);
        multi_touch_block_in <= 1'b0;
        pattern_detect_enable_in <= 1'b1;
        pattern_alert_enable_in <= 1'b1;
        pattern_above_in <= 8'h01;
        noise_lowfreq_in <= 8'h01;
        wr(8'h00, 8'h00);
        tick(3);
        #1 chk("alert_n", alert_n_out, 1'b1);
        chk("delta_ch1", delta_out[7:0], 8'h00);
        tick(1);
        noise_lowfreq_in <= 8'h02;
        tick(3);
        #1 chk("alert_n", alert_n_out, 1'b0);
        chk("delta_ch3", delta_out[23:16], 8'h33);
        chk("discard", sample_discard_out, 8'h02);
        rdc(8'h0A, 8'h02);
        rdc(8'h02, 8'h02);
        wr(8'h00, 8'h00);
        rdc(8'h02, 8'h02);
        #1 chk("alert_n", alert_n_out, 1'b1);
        tick(1);
        lowfreq_noise_filter_off_in <= 1'b1;
        noise_rf_in <= 8'h80;
        tick(1);
        #1 chk("discard", sample_discard_out, 8'h80);
        tick(1);
        {noise_lowfreq_in, noise_rf_in, pattern_above_in} <= 24'h0;
        rdc(8'h0A, 8'h00);
        wr(8'h00, 8'h00);
        // Deep sleep entry and wake by pin
        tick(1);
        chan_int_enable_in <= 8'hFF;
        touch_detect_in <= 8'h01;
        tick(3);
        wr(8'h00, 8'h10);
        #1 chk("pwm", pwm_enable_out, 1'b0);
        chk("alert_n", alert_n_out, 1'b1);
        rdc(8'h03, 8'h00);
        tick(1);
        touch_detect_in <= 8'h00;
        wake_pin_in <= 1'b1;
        tick(9);
        wake_pin_in <= 1'b0;
        #1 chk("led_idle", led_idle_force_out, 1'b0);
        rdc(8'h00, 8'h00);
        // Qualified reset pin event
        tick(1);
        reset_pin_qualified_in <= 1'b1;
        tick(1);
        reset_pin_qualified_in <= 1'b0;
        rdc(8'h02, 8'h08);
        wr(8'h00, 8'h00);
        rdc(8'h02, 8'h00);
        stop_test;
    end
endmodule // touch_power_status_regs_tb
